/* scpm_pkg.sv */
// Package for the strap configuration and pin multiplexing block
package scpm_pkg;

  // ----------------------------------------------------------------
  // Strap field positions
  // ----------------------------------------------------------------
  localparam int STRAP_W        = 7;
  localparam int STRAP_CS_BIT   = 6;
  localparam int STRAP_BO_BIT   = 5;
  localparam int STRAP_BUS_HI   = 4;
  localparam int STRAP_BUS_LO   = 2;
  localparam int STRAP_GPIO_BIT = 1;
  localparam int STRAP_WAIT_BIT = 0;
  localparam logic [6:0] STRAP_RST = 7'h00;

  // ----------------------------------------------------------------
  // GPIO layout
  // ----------------------------------------------------------------
  localparam int GPIO_W          = 22;
  localparam int GPIO_HOST_CS    = 19;
  localparam int GPIO_STROBE     = 20;
  localparam int GPIO_LCD_TOP    = 13;
  localparam int GPIO_RGB_LO     = 4;
  localparam int GPIO_RGB_HI     = 9;
  localparam int PANEL_DATA_W    = 18;
  localparam int PANEL_HIZ_BIT   = 13;
  localparam logic [21:0] GPIO_ZERO = 22'h00_0000;

  // ----------------------------------------------------------------
  // Host bus types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_D80_T2 = 3'b000,
    BUS_D80_T3 = 3'b001,
    BUS_I80_T2 = 3'b010,
    BUS_I80_T3 = 3'b011,
    BUS_D80_T1 = 3'b100,
    BUS_D68    = 3'b101,
    BUS_I80_T1 = 3'b110,
    BUS_I68    = 3'b111
  } scpm_bus_e;

  // Strobe scheme used on the host strobe pins
  typedef enum logic [1:0] {
    STB_RW_DS  = 2'b00,
    STB_RD_BE  = 2'b01,
    STB_RD_WEX = 2'b10,
    STB_SPLIT  = 2'b11
  } scpm_stb_e;

  // Indirect types are exactly those with bit 1 set; bits 2 and 0 don't care
  function automatic logic scpm_is_indirect(input logic [2:0] bus);
    scpm_is_indirect = (bus == BUS_I80_T2) || (bus == BUS_I80_T3) ||
                       (bus == BUS_I80_T1) || (bus == BUS_I68);
  endfunction : scpm_is_indirect

endpackage : scpm_pkg

/* scpm_strap_mux.sv */
// Strap capture, host bus decode and GPIO/LCD pin multiplexing
//
// Overview of operation
// - Capture seven straps at reset release only
// - Chip-select strap high gives two-select mode
// - Indirect bus types force one-select mode
// - Byte-order strap high means big endian
// - Three-bit strap field selects host bus type
// - Direction strap high: GPIO inputs, software adjustable
// - Direction strap low: GPIO outputs, software ignored
// - GPIO 21..3 and 0 zero at reset
// - Panel bit 13 set at reset release makes GPIO 2..1 float
// - Direct bus with wait strap: wait when needed
// - Wait strap low: wait never asserted
// - Indirect bus types never use wait
// - PLL mode: clock pin is 32.768 kHz reference
// - PLL bypassed: clock pin is system clock
// - Serial bypass or power save: GPIO19 host select
// - Strobe enable drives camera strobe on GPIO20
// - LCD panel type takes over GPIO 13..0
// - Strobe assignment by bus type; indirect address low
// - Two-select direct: memory and register space selects
// - Generic TFT mode drives syncs and 18 RGB bits
module scpm_strap_mux (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_rst,
  input  wire logic [scpm_pkg::STRAP_W-1:0] i_strap_inputs,
  input  wire logic                         i_pll_bypass,
  input  wire logic                         i_clock_input_pin,
  input  wire logic                         i_pll_clk,
  input  wire logic                         i_core_need_wait,
  input  wire logic                         i_cs_n,
  input  wire logic                         i_mr_n,
  input  wire logic [scpm_pkg::GPIO_W-1:0]  i_gpio_dir_out,
  input  wire logic [scpm_pkg::GPIO_W-1:0]  i_gpio_out_val,
  input  wire logic [scpm_pkg::GPIO_W-1:0]  i_gpio_pin,
  input  wire logic                         i_panel_ctl_a_b13,
  input  wire logic                         i_panel_ctl_b_b13,
  input  wire logic                         i_serial_bypass,
  input  wire logic                         i_power_save,
  input  wire logic                         i_strobe_en,
  input  wire logic                         i_strobe_ctl,
  input  wire logic                         i_lcd_generic_tft,
  input  wire logic [13:0]                  i_lcd_gpio_use,
  input  wire logic [13:0]                  i_lcd_gpio_val,
  input  wire logic                         i_tft_vsync,
  input  wire logic                         i_tft_hsync,
  input  wire logic                         i_tft_pclk,
  input  wire logic                         i_tft_de,
  input  wire logic [17:0]                  i_tft_rgb,
  output logic                              o_two_cs_mode,
  output logic                              o_big_endian,
  output logic [2:0]                        o_host_bus_type,
  output logic                              o_bus_indirect,
  output logic [1:0]                        o_strobe_scheme,
  output logic                              o_upper_addr_used,
  output logic                              o_gpio_default_in,
  output logic                              o_wait_n,
  output logic                              o_pll_ref_clk,
  output logic                              o_system_clock,
  output logic                              o_memory_space_sel,
  output logic                              o_register_space_sel,
  output logic                              o_host_serial_chip_select_n,
  output logic [scpm_pkg::GPIO_W-1:0]       o_gpio_out,
  output logic [scpm_pkg::GPIO_W-1:0]       o_gpio_oe_n,
  output logic [scpm_pkg::GPIO_W-1:0]       o_gpio_in,
  output logic                              o_panel_frame_pin,
  output logic                              o_panel_line_pin,
  output logic                              o_panel_pixel_clock_pin,
  output logic                              o_panel_data_enable_pin,
  output logic [scpm_pkg::PANEL_DATA_W-1:0] o_panel_data_pins
);
  import scpm_pkg::*;

  // ----------------------------------------------------------------
  // Reset release detection and strap capture
  // ----------------------------------------------------------------
  logic [STRAP_W-1:0] strap_s1_q, strap_s1_d;
  logic [STRAP_W-1:0] strap_s2_q, strap_s2_d;
  logic [STRAP_W-1:0] strap_q, strap_d;
  logic               rel_q, rel_d;
  logic               hiz12_q, hiz12_d;
  logic               panel_hiz;

  assign panel_hiz = i_panel_ctl_a_b13 | i_panel_ctl_b_b13;

  always_comb begin
    strap_s1_d = i_strap_inputs;
    strap_s2_d = strap_s1_q;
    rel_d      = 1'b1;
    strap_d    = strap_q;
    hiz12_d    = hiz12_q;
    // Sample once, on the first edge after reset release
    if (!rel_q) begin
      strap_d = strap_s2_q;
      hiz12_d = panel_hiz;
    end
  end

  // Strap synchroniser runs through reset so stage 2 is settled at release
  always_ff @(posedge i_clk_sys) begin
    strap_s1_q <= strap_s1_d;
    strap_s2_q <= strap_s2_d;
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      strap_q    <= STRAP_RST;
      rel_q      <= 1'b0;
      hiz12_q    <= 1'b0;
    end else begin
      strap_q    <= strap_d;
      rel_q      <= rel_d;
      hiz12_q    <= hiz12_d;
    end
  end

  // ----------------------------------------------------------------
  // Host bus configuration decode
  // ----------------------------------------------------------------
  logic [2:0] bus;
  logic       indirect;
  logic       wait_use;

  assign bus      = strap_q[STRAP_BUS_HI:STRAP_BUS_LO];
  assign indirect = scpm_is_indirect(bus);
  assign wait_use = strap_q[STRAP_WAIT_BIT] & ~indirect;

  always_comb begin
    o_host_bus_type   = bus;
    o_bus_indirect    = indirect;
    o_two_cs_mode     = strap_q[STRAP_CS_BIT] & ~indirect;
    o_big_endian      = strap_q[STRAP_BO_BIT];
    o_gpio_default_in = strap_q[STRAP_GPIO_BIT];
    o_upper_addr_used = ~indirect;
    case (bus)
      BUS_D68, BUS_I68:       o_strobe_scheme = STB_RW_DS;
      BUS_D80_T1, BUS_I80_T1: o_strobe_scheme = STB_RD_BE;
      BUS_D80_T2, BUS_I80_T2: o_strobe_scheme = STB_RD_WEX;
      BUS_D80_T3, BUS_I80_T3: o_strobe_scheme = STB_SPLIT;
      default:                o_strobe_scheme = STB_RD_BE;
    endcase
  end

  // Wait only on cycles the core flags, and only when allowed
  always_comb begin
    o_wait_n = ~(wait_use & i_core_need_wait & rel_q);
  end

  // Space selects, active high
  always_comb begin
    if (o_two_cs_mode) begin
      o_memory_space_sel   = ~i_cs_n;
      o_register_space_sel = ~i_mr_n;
    end else begin
      o_memory_space_sel   = ~i_cs_n & i_mr_n;
      o_register_space_sel = ~i_cs_n & ~i_mr_n & ~indirect;
    end
  end

  // ----------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------
  assign o_pll_ref_clk  = i_pll_bypass ? 1'b0 : i_clock_input_pin;
  assign o_system_clock = i_pll_bypass ? i_clock_input_pin : i_pll_clk;

  // ----------------------------------------------------------------
  // GPIO input synchronisers
  // ----------------------------------------------------------------
  logic [GPIO_W-1:0] gin_s1_q, gin_s1_d;
  logic [GPIO_W-1:0] gin_s2_q, gin_s2_d;

  always_comb begin
    gin_s1_d = i_gpio_pin;
    gin_s2_d = gin_s1_q;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      gin_s1_q <= GPIO_ZERO;
      gin_s2_q <= GPIO_ZERO;
    end else begin
      gin_s1_q <= gin_s1_d;
      gin_s2_q <= gin_s2_d;
    end
  end

  // ----------------------------------------------------------------
  // GPIO pin multiplexing
  // ----------------------------------------------------------------
  logic [GPIO_W-1:0] out_d, out_q;
  logic [GPIO_W-1:0] oe_n_d, oe_n_q;
  logic              host_cs_in;

  assign host_cs_in = i_serial_bypass | i_power_save;

  generate
    for (genvar g = 0; g < GPIO_W; g++) begin : g_gpio
      localparam int LCD_IDX = (g <= GPIO_LCD_TOP) ? g : 0;
      localparam int RGB_IDX = (g >= GPIO_RGB_LO && g <= GPIO_RGB_HI) ? GPIO_RGB_HI - g : 0;
      always_comb begin
        if (strap_q[STRAP_GPIO_BIT]) begin
          oe_n_d[g] = ~i_gpio_dir_out[g];
        end else begin
          oe_n_d[g] = 1'b0;
        end
        out_d[g] = i_gpio_out_val[g];
        if ((g == 1 || g == 2) && hiz12_q) begin
          oe_n_d[g] = 1'b1;
        end
        if (g <= GPIO_LCD_TOP) begin
          if (i_lcd_gpio_use[LCD_IDX]) begin
            oe_n_d[g] = 1'b0;
            out_d[g]  = i_lcd_gpio_val[LCD_IDX];
          end
          if (i_lcd_generic_tft && g >= GPIO_RGB_LO && g <= GPIO_RGB_HI) begin
            oe_n_d[g] = 1'b0;
            out_d[g]  = i_tft_rgb[RGB_IDX];
          end
        end
        if (g == GPIO_HOST_CS && host_cs_in) begin
          oe_n_d[g] = 1'b1;
        end
        if (g == GPIO_STROBE && i_strobe_en) begin
          oe_n_d[g] = 1'b0;
          out_d[g]  = i_strobe_ctl;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_q  <= GPIO_ZERO;
      oe_n_q <= ~GPIO_ZERO;
    end else begin
      out_q  <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Pins float with zero values in reset; the first cycle after release drives them per the all-zero reset strap
  assign o_gpio_out  = out_q;
  assign o_gpio_oe_n = oe_n_q;
  assign o_gpio_in   = gin_s2_q;
  assign o_host_serial_chip_select_n = host_cs_in ? gin_s2_q[GPIO_HOST_CS] : 1'b1;

  // ----------------------------------------------------------------
  // Panel control and data pins
  // ----------------------------------------------------------------
  logic [3:0]              pctl_d, pctl_q;
  logic [PANEL_DATA_W-1:0] pdat_d, pdat_q;

  always_comb begin
    if (i_lcd_generic_tft) begin
      pctl_d = {i_tft_vsync, i_tft_hsync, i_tft_pclk, i_tft_de};
      pdat_d = i_tft_rgb;
    end else begin
      pctl_d = 4'h0;
      pdat_d = 18'h0_0000;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pctl_q <= 4'h0;
      pdat_q <= 18'h0_0000;
    end else begin
      pctl_q <= pctl_d;
      pdat_q <= pdat_d;
    end
  end

  assign o_panel_frame_pin       = pctl_q[3];
  assign o_panel_line_pin        = pctl_q[2];
  assign o_panel_pixel_clock_pin = pctl_q[1];
  assign o_panel_data_enable_pin = pctl_q[0];
  assign o_panel_data_pins       = pdat_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_strap_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
    rel_q |=> (strap_q == $past(strap_q));
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

  property p_indirect_one_cs;
    @(posedge i_clk_sys) disable iff (i_rst)
    indirect |-> !o_two_cs_mode;
  endproperty
  a_indirect_one_cs: assert property (p_indirect_one_cs) else $error("two-select on indirect");

  property p_two_cs;
    @(posedge i_clk_sys) disable iff (i_rst)
    (strap_q[STRAP_CS_BIT] && !indirect) |-> o_two_cs_mode;
  endproperty
  a_two_cs: assert property (p_two_cs) else $error("two-select mode missing");

  property p_no_wait;
    @(posedge i_clk_sys) disable iff (i_rst)
    (!strap_q[STRAP_WAIT_BIT] || indirect) |-> o_wait_n;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait asserted while unused");

  property p_wait_when_needed;
    @(posedge i_clk_sys) disable iff (i_rst)
    (rel_q && wait_use) |-> (o_wait_n == !i_core_need_wait);
  endproperty
  a_wait_when_needed: assert property (p_wait_when_needed) else $error("wait not tied to need");

  property p_gpio_out_mode;
    @(posedge i_clk_sys) disable iff (i_rst)
    (rel_q && !strap_q[STRAP_GPIO_BIT] && !i_serial_bypass && !i_power_save && !hiz12_q)
      |=> (oe_n_q == GPIO_ZERO);
  endproperty
  a_gpio_out_mode: assert property (p_gpio_out_mode) else $error("GPIO not all outputs");

  property p_strobe_pin;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_strobe_en |=> (!oe_n_q[GPIO_STROBE] && out_q[GPIO_STROBE] == $past(i_strobe_ctl));
  endproperty
  a_strobe_pin: assert property (p_strobe_pin) else $error("strobe not on GPIO20");

  property p_host_cs_in;
    @(posedge i_clk_sys) disable iff (i_rst)
    host_cs_in |=> oe_n_q[GPIO_HOST_CS];
  endproperty
  a_host_cs_in: assert property (p_host_cs_in) else $error("GPIO19 driven in bypass");

  property p_tft_data;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_lcd_generic_tft |=> (o_panel_data_pins == $past(i_tft_rgb));
  endproperty
  a_tft_data: assert property (p_tft_data) else $error("panel data mismatch");

endmodule : scpm_strap_mux

/* scpm_host_model.sv */
// Host CPU model driving the chip select and memory/register select pins
module scpm_host_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_req,
  input  wire logic i_to_mem,
  input  wire logic i_two_cs,
  input  wire logic i_indirect,
  output logic      o_cs_n,
  output logic      o_mr_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Access generator
  // ----------------------------------------------------------------
  // Each access is held for a fixed stretch, since no wait is relied upon
  localparam int HOLD = 3;
  int unsigned left;

  always @(negedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cs_n <= 1'b1;
      o_mr_n <= 1'b1;
      left   <= 0;
    end else if (left != 0) begin
      left <= left - 1;
    end else if (i_req) begin
      left <= HOLD - 1;
      if (i_indirect) begin
        o_cs_n <= 1'b0;
        o_mr_n <= i_two_cs;
      end else begin
        o_cs_n <= i_two_cs & ~i_to_mem;
        o_mr_n <= i_to_mem;
      end
    end else begin
      o_cs_n <= 1'b1;
      o_mr_n <= 1'b1;
    end
  end
endmodule : scpm_host_model

/* tb_scpm_strap_mux.sv */
// Self-checking testbench for strap capture and pin multiplexing
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module tb_scpm_strap_mux;
  timeunit 1ns;
  timeprecision 1ns;
  import scpm_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst, byp, clk_pin, pll_clk, need, cs_n, mr_n, pa, pb, ser, pws;
  logic        stb_en, stb_ctl, tft, vs, hs, pc, de, req, to_mem, hz;
  logic        two_cs, big_end, indir, up_addr, def_in, wait_n, pll_ref, sys_clk;
  logic        mem_sel, reg_sel, hcs_n, pf, pl, pp, pd;
  logic [1:0]  stb_sch;
  logic [2:0]  bus_type;
  logic [6:0]  strap, s;
  logic [13:0] lcd_use, lcd_val;
  logic [17:0] rgb, pdat;
  logic [21:0] dir_out, out_val, pin, gpio_out, gpio_oe_n, gpio_in, oe_x;
  int          seed, num_errors, check_count;

  always #10 clk = ~clk;

  scpm_strap_mux DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_strap_inputs(strap), .i_pll_bypass(byp),
    .i_clock_input_pin(clk_pin), .i_pll_clk(pll_clk), .i_core_need_wait(need),
    .i_cs_n(cs_n), .i_mr_n(mr_n), .i_gpio_dir_out(dir_out), .i_gpio_out_val(out_val),
    .i_gpio_pin(pin), .i_panel_ctl_a_b13(pa), .i_panel_ctl_b_b13(pb),
    .i_serial_bypass(ser), .i_power_save(pws), .i_strobe_en(stb_en), .i_strobe_ctl(stb_ctl),
    .i_lcd_generic_tft(tft), .i_lcd_gpio_use(lcd_use), .i_lcd_gpio_val(lcd_val),
    .i_tft_vsync(vs), .i_tft_hsync(hs), .i_tft_pclk(pc), .i_tft_de(de), .i_tft_rgb(rgb),
    .o_two_cs_mode(two_cs), .o_big_endian(big_end), .o_host_bus_type(bus_type),
    .o_bus_indirect(indir), .o_strobe_scheme(stb_sch), .o_upper_addr_used(up_addr),
    .o_gpio_default_in(def_in), .o_wait_n(wait_n), .o_pll_ref_clk(pll_ref),
    .o_system_clock(sys_clk), .o_memory_space_sel(mem_sel), .o_register_space_sel(reg_sel),
    .o_host_serial_chip_select_n(hcs_n), .o_gpio_out(gpio_out), .o_gpio_oe_n(gpio_oe_n),
    .o_gpio_in(gpio_in), .o_panel_frame_pin(pf), .o_panel_line_pin(pl),
    .o_panel_pixel_clock_pin(pp), .o_panel_data_enable_pin(pd), .o_panel_data_pins(pdat)
  );

  scpm_host_model HOST (
    .i_clk(clk), .i_rst(rst), .i_req(req), .i_to_mem(to_mem),
    .i_two_cs(s[6] & ~s[3]), .i_indirect(s[3]), .o_cs_n(cs_n), .o_mr_n(mr_n)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] exp_scheme(input logic [2:0] b);
    return b[2] ? {1'b0, ~b[0]} : {1'b1, b[0]};
  endfunction : exp_scheme

  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic do_reset(input logic [6:0] c, input logic a, input logic b);
    @(negedge clk);
    rst = 1'b1;
    strap = c;
    {pa, pb} = {a, b};
    repeat (5) @(negedge clk);
    `CHK(gpio_out, GPIO_ZERO)
    `CHK(gpio_oe_n, ~GPIO_ZERO)
    rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask : do_reset

  task automatic check_cfg(input logic [6:0] c);
    `CHK(bus_type, c[4:2])
    `CHK(indir, c[3])
    `CHK(two_cs, c[6] & ~c[3])
    `CHK(big_end, c[5])
    `CHK(def_in, c[1])
    `CHK(stb_sch, exp_scheme(c[4:2]))
    `CHK(up_addr, ~c[3])
  endtask : check_cfg

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h1f03_b5e0;
    {clk, byp, clk_pin, pll_clk, need, pa, pb, ser, pws, stb_en, stb_ctl} = '0;
    {tft, vs, hs, pc, de, req, to_mem, strap, s, lcd_use, lcd_val, rgb} = '0;
    {dir_out, out_val, pin, num_errors, check_count} = '0;
    rst = 1'b1;
    for (int n = 0; n < 16; n++) begin
      s = 7'($random(seed));
      s[4:2] = 3'(n);
      {pa, pb} = 2'($random(seed));
      hz = pa | pb;
      do_reset(s, pa, pb);
      check_cfg(s);
      strap = ~s;
      {pa, pb} = ~{pa, pb};
      for (int k = 0; k < 8; k++) begin
        @(negedge clk);
        {need, byp, clk_pin, pll_clk} = 4'($random(seed));
        #2;
        `CHK(wait_n, ~(need & s[0] & ~s[3]))
        `CHK(sys_clk, byp ? clk_pin : pll_clk)
        `CHK(pll_ref, ~byp & clk_pin)
      end
      check_cfg(s);
      // Software direction and values
      dir_out = 22'($random(seed));
      out_val = 22'($random(seed));
      repeat (2) @(negedge clk);
      oe_x = s[1] ? ~dir_out : GPIO_ZERO;
      if (hz) oe_x[2:1] = 2'b11;
      `CHK(gpio_oe_n, oe_x)
      `CHK(gpio_out & ~oe_x, out_val & ~oe_x)
      // Host selects
      for (int k = 0; k < 12; k++) begin
        @(negedge clk);
        {req, to_mem} <= 2'($random(seed));
        #2;
        if (!s[3]) begin
          `CHK(mem_sel, ~cs_n & (s[6] | mr_n))
          `CHK(reg_sel, s[6] ? ~mr_n : ~cs_n & ~mr_n)
        end else begin
          `CHK(reg_sel, 1'b0)
        end
      end
      // Strobe, host serial select and LCD takeover
      @(negedge clk);
      {ser, pws} = 2'(n);
      {stb_en, stb_ctl} = {1'b1, 1'($random(seed))};
      {lcd_use, lcd_val} = 28'($random(seed));
      pin = 22'($random(seed));
      repeat (3) @(negedge clk);
      `CHK(gpio_out[GPIO_STROBE], stb_ctl)
      `CHK(gpio_oe_n[GPIO_STROBE], 1'b0)
      `CHK(hcs_n, (ser | pws) ? pin[GPIO_HOST_CS] : 1'b1)
      if (ser | pws) `CHK(gpio_oe_n[GPIO_HOST_CS], 1'b1)
      `CHK(gpio_out[13:0] & lcd_use, lcd_val & lcd_use)
      `CHK(gpio_oe_n[13:0] & lcd_use, 14'h0000)
      `CHK(gpio_in, pin)
      // Generic TFT panel
      tft = 1'b1;
      {vs, hs, pc, de} = 4'($random(seed));
      rgb = 18'($random(seed));
      repeat (2) @(negedge clk);
      `CHK({pf, pl, pp, pd}, {vs, hs, pc, de})
      `CHK(pdat, rgb)
      for (int g = GPIO_RGB_LO; g <= GPIO_RGB_HI; g++) begin
        `CHK({gpio_out[g], gpio_oe_n[g]}, {rgb[9 - g], 1'b0})
      end
      {tft, stb_en, ser, pws, lcd_use} = '0;
    end
    conclude();
  end

  initial begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule : tb_scpm_strap_mux
